// ==== hw/conv_ctrl_pkg.sv ====
// register map, field positions and reset values of the converter control
// block; shared by the design and by anything that talks to it
package conv_ctrl_pkg;
   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h04;
   localparam logic [7:0]  OFS_CONTROL     = 8'h08;
   localparam logic [7:0]  OFS_CONFIG_ONE  = 8'h0C;
   localparam logic [7:0]  OFS_CONFIG_TWO  = 8'h10;
   localparam logic [7:0]  OFS_SAMPLE_TIME = 8'h14;
   localparam logic [7:0]  OFS_CONFIG_THREE = 8'h18;
   // status / irq-enable bit positions
   localparam int BIT_READY     = 0;
   localparam int BIT_SMP_END   = 1;
   localparam int BIT_CONV_END  = 2;
   localparam int BIT_SEQ_END   = 3;
   localparam int BIT_OVERRUN   = 4;
   localparam int BIT_WATCHDOG  = 7;
   localparam int BIT_SEG3_DONE = 8;
   localparam int BIT_SEG1_DONE = 9;
   localparam int BIT_SEG2_DONE = 10;
   localparam logic [31:0] STATUS_MASK = 32'h0000079F;
   // control bits
   localparam int BIT_ENABLE    = 0;
   localparam int BIT_DISABLE   = 1;
   localparam int BIT_START     = 2;
   localparam int BIT_STOP      = 4;
   localparam int BIT_CAL       = 31;
   // writable masks of the configuration registers
   localparam logic [31:0] CFG1_MASK  = 32'h7CC1FFFF;
   localparam logic [31:0] CFG2_MASK  = 32'hFC7FFF01;
   localparam logic [31:0] SMP_MASK   = 32'h00000007;
   localparam logic [31:0] CFG3_MASK  = 32'h00003F3F;
   localparam logic [31:0] RESET_ZERO = 32'h00000000;
   // config one fields
   localparam int CFG1_DMA_EN   = 0;
   localparam int CFG1_DMA_CIRC = 1;
   localparam int CFG1_SCAN_BK  = 2;
   localparam int CFG1_RES_LO   = 3;
   localparam int CFG1_ALIGN    = 5;
   localparam int CFG1_TEV_LO   = 6;
   localparam int CFG1_TEDGE_LO = 10;
   localparam int CFG1_OVR      = 12;
   localparam int CFG1_CONT     = 13;
   localparam int CFG1_WAIT     = 14;
   localparam int CFG1_AUTO_OFF = 15;
   localparam int CFG1_DISC     = 16;
   localparam int CFG1_WD_SINGLE = 22;
   localparam int CFG1_WD_EN    = 23;
   localparam int CFG1_WD_CH_LO = 26;
   // config two fields
   localparam int CFG2_SEG_EN   = 0;
   localparam int CFG2_GAP_LO   = 8;
   localparam int CFG2_CSRC     = 26;
   localparam int CFG2_DIV_LO   = 27;
   localparam int CFG2_CMODE_LO = 30;
   // config three fields
   localparam int CFG3_E2_LO    = 0;
   localparam int CFG3_T2_LO    = 2;
   localparam int CFG3_E3_LO    = 8;
   localparam int CFG3_T3_LO    = 10;
   localparam logic [4:0] WD_CH_MAX = 5'h12;
   // sampling duration in half converter clock cycles, per code
   localparam logic [8:0] SMP_HALF_CYC [8] = '{9'h003, 9'h00F, 9'h01B,
      9'h039, 9'h053, 9'h06F, 9'h08F, 9'h1DF};
   typedef enum logic [1:0] {
      CORE_OFF, CORE_ON, CORE_CONV, CORE_CAL
   } core_state_e;
endpackage

// ==== hw/conv_ctrl.sv ====
// converter control and configuration registers, reached over avalon-mm
// assumes the analog core reports its events as single-cycle pulses on
// core_clk and acknowledges disable, stop and calibration by pulses
//
// Function
// - segment finish flags set, cleared by one
// - irq enables mirror flags; irq when both set
// - irq enable and configs locked while converting
// - enable settable only when control all zero
// - disable needs enable, no start; self clears
// - start needs enable and not disable
// - stop needs start and not disable
// - calibrate only while disabled; clears when done
// - dma enable, circular mode only when enabled
// - scan direction upward or downward
// - result alignment right or left
// - trigger event and edge selection
// - overrun keeps or overwrites data
// - continuous, wait, auto-off, discontinuous bits
// - watchdog enable, single channel, channel select
// - segmented sampling enable bit
// - gap cycles between conversions in segments
// - converter clock source and divider
// - config two writable only when fully idle
// - sampling duration code table
// - segment two and three triggers
// - resolution twelve, ten, eight or six bits
`timescale 1ns/1ps
module conv_ctrl
   import conv_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // avalon-mm slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // events from the analog core, one-cycle pulses
   input  wire logic [10:0] core_event,
   input  wire logic        core_ready_ack,
   input  wire logic        core_off_ack,
   input  wire logic        core_conv_done,
   input  wire logic        core_stop_ack,
   input  wire logic        core_cal_done,
   // control and configuration to the core
   output logic             conv_enable,
   output logic             conv_disable,
   output logic             start_conv,
   output logic             stop_conv,
   output logic             cal_busy,
   output logic             irq_out,
   output logic             dma_enable,
   output logic             dma_circular,
   output logic             scan_backward,
   output logic [1:0]       resolution_sel,
   output logic             left_align,
   output logic [3:0]       trig_event_sel,
   output logic [1:0]       trig_edge_sel,
   output logic             overrun_overwrite,
   output logic             continuous_sel,
   output logic             wait_mode_en,
   output logic             auto_off_en,
   output logic             discontinuous_en,
   output logic             wd_enable,
   output logic             wd_single_channel,
   output logic [4:0]       wd_channel_sel,
   output logic             segmented_en,
   output logic [14:0]      conv_gap_cycles,
   output logic             clock_source_sel,
   output logic [2:0]       bus_clock_divider,
   output logic [1:0]       clock_mode_sel,
   output logic [8:0]       sample_half_cycles,
   output logic [3:0]       seg2_trig_event,
   output logic [1:0]       seg2_trig_edge,
   output logic [3:0]       seg3_trig_event,
   output logic [1:0]       seg3_trig_edge,
   output logic             core_powered
);
   // -------------------------------------------------------------
   // bus handshake
   // -------------------------------------------------------------
   // one wait cycle: request seen, answered the next edge
   logic        ack_q;
   logic        req;
   logic        wr_go;
   logic        rd_go;
   logic [31:0] wmask;
   logic [31:0] wdat;

   assign req   = (read | write) & ~ack_q;
   assign wr_go = write & ack_q;
   assign rd_go = read & ack_q;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{byteenable[i]}};
      end
      wdat = writedata & wmask;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_q       <= 1'b0;
         waitrequest <= 1'b1;
      end else begin
         ack_q       <= req;
         waitrequest <= ~req;
      end
   end

   // -------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------
   logic [31:0] status_q;
   logic [31:0] irq_en_q;
   logic [31:0] ctrl_q;
   logic [31:0] cfg1_q;
   logic [31:0] cfg2_q;
   logic [31:0] smp_q;
   logic [31:0] cfg3_q;
   logic        converting;
   logic        idle_all;

   assign converting = ctrl_q[BIT_START];
   assign idle_all   = ~ctrl_q[BIT_START] & ~cfg1_q[CFG1_DISC]
                     & ~ctrl_q[BIT_CAL] & ~ctrl_q[BIT_STOP]
                     & ~ctrl_q[BIT_ENABLE];

   // -------------------------------------------------------------
   // status flags
   // -------------------------------------------------------------
   // set beats clear so an event in the clearing cycle survives
   logic [31:0] st_clr;

   assign st_clr = (wr_go && address == OFS_STATUS) ? wdat : RESET_ZERO;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         status_q <= RESET_ZERO;
      end else begin
         status_q <= ((status_q & ~st_clr)
                     | {21'h000000, core_event}) & STATUS_MASK;
      end
   end

   // -------------------------------------------------------------
   // locked configuration registers
   // -------------------------------------------------------------
   // refused writes just leave the register as it was
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_en_q <= RESET_ZERO;
         cfg1_q   <= RESET_ZERO;
         smp_q    <= RESET_ZERO;
         cfg3_q   <= RESET_ZERO;
      end else if (wr_go && !converting) begin
         case (address)
            OFS_IRQ_ENABLE:
               irq_en_q <= (irq_en_q & ~wmask) | (wdat & STATUS_MASK);
            OFS_CONFIG_ONE:
               cfg1_q <= (cfg1_q & ~wmask) | (wdat & CFG1_MASK);
            OFS_SAMPLE_TIME:
               smp_q <= (smp_q & ~wmask) | (wdat & SMP_MASK);
            OFS_CONFIG_THREE:
               cfg3_q <= (cfg3_q & ~wmask) | (wdat & CFG3_MASK);
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cfg2_q <= RESET_ZERO;
      end else if (wr_go && address == OFS_CONFIG_TWO && idle_all) begin
         cfg2_q <= (cfg2_q & ~wmask) | (wdat & CFG2_MASK);
      end
   end

   // -------------------------------------------------------------
   // control bits: software sets, hardware clears
   // -------------------------------------------------------------
   core_state_e state_q;
   logic [31:0] sw_set;
   logic [31:0] ctrl_d;

   assign sw_set = (wr_go && address == OFS_CONTROL) ? wdat : RESET_ZERO;

   always_comb begin
      ctrl_d = ctrl_q;
      if (sw_set[BIT_ENABLE] && ctrl_q == RESET_ZERO) begin
         ctrl_d[BIT_ENABLE] = 1'b1;
      end
      if (sw_set[BIT_DISABLE] && ctrl_q[BIT_ENABLE]
          && !ctrl_q[BIT_START]) begin
         ctrl_d[BIT_DISABLE] = 1'b1;
      end
      if (sw_set[BIT_START] && ctrl_q[BIT_ENABLE]
          && !ctrl_q[BIT_DISABLE]) begin
         ctrl_d[BIT_START] = 1'b1;
      end
      if (sw_set[BIT_STOP] && ctrl_q[BIT_START] && !ctrl_q[BIT_DISABLE]) begin
         ctrl_d[BIT_STOP] = 1'b1;
      end
      if (sw_set[BIT_CAL] && !ctrl_q[BIT_ENABLE] && state_q == CORE_OFF) begin
         ctrl_d[BIT_CAL] = 1'b1;
      end
      // hardware clears follow the core acknowledgements
      if (core_off_ack && ctrl_q[BIT_DISABLE]) begin
         ctrl_d[BIT_DISABLE] = 1'b0;
         ctrl_d[BIT_ENABLE]  = 1'b0;
         ctrl_d[BIT_START]   = 1'b0;
         ctrl_d[BIT_STOP]    = 1'b0;
      end
      if (core_stop_ack && ctrl_q[BIT_STOP]) begin
         ctrl_d[BIT_STOP]  = 1'b0;
         ctrl_d[BIT_START] = 1'b0;
      end
      if (core_conv_done && ctrl_q[BIT_START]) begin
         ctrl_d[BIT_START] = 1'b0;
      end
      if (core_cal_done && ctrl_q[BIT_CAL]) begin
         ctrl_d[BIT_CAL] = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_q  <= RESET_ZERO;
         state_q <= CORE_OFF;
      end else begin
         ctrl_q <= ctrl_d;
         case (state_q)
            CORE_OFF:  if (ctrl_d[BIT_CAL]) state_q <= CORE_CAL;
                       else if (ctrl_d[BIT_ENABLE]) state_q <= CORE_ON;
            CORE_CAL:  if (!ctrl_d[BIT_CAL]) state_q <= CORE_OFF;
            CORE_ON:   if (!ctrl_d[BIT_ENABLE]) state_q <= CORE_OFF;
                       else if (ctrl_d[BIT_START]) state_q <= CORE_CONV;
            CORE_CONV: if (!ctrl_d[BIT_ENABLE]) state_q <= CORE_OFF;
                       else if (!ctrl_d[BIT_START]) state_q <= CORE_ON;
            default:   state_q <= CORE_OFF;
         endcase
      end
   end

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         readdata <= RESET_ZERO;
      end else if (req && read) begin
         case (address)
            OFS_STATUS:       readdata <= status_q;
            OFS_IRQ_ENABLE:   readdata <= irq_en_q;
            OFS_CONTROL:      readdata <= ctrl_q;
            OFS_CONFIG_ONE:   readdata <= cfg1_q;
            OFS_CONFIG_TWO:   readdata <= cfg2_q;
            OFS_SAMPLE_TIME:  readdata <= smp_q;
            OFS_CONFIG_THREE: readdata <= cfg3_q;
            default:          readdata <= RESET_ZERO;
         endcase
      end
   end

   // -------------------------------------------------------------
   // outputs to the core
   // -------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_out      <= 1'b0;
         conv_enable  <= 1'b0;
         conv_disable <= 1'b0;
         start_conv   <= 1'b0;
         stop_conv    <= 1'b0;
         cal_busy     <= 1'b0;
         core_powered <= 1'b0;
      end else begin
         irq_out      <= |(status_q & irq_en_q & STATUS_MASK);
         conv_enable  <= ctrl_q[BIT_ENABLE];
         conv_disable <= ctrl_q[BIT_DISABLE];
         start_conv   <= ctrl_q[BIT_START];
         stop_conv    <= ctrl_q[BIT_STOP];
         cal_busy     <= ctrl_q[BIT_CAL];
         core_powered <= state_q != CORE_OFF;
      end
   end

   // decoded config fields; sampling time becomes half-cycle count
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dma_enable <= 1'b0;
         dma_circular <= 1'b0;
         scan_backward <= 1'b0;
         resolution_sel <= 2'h0;
         left_align <= 1'b0;
         trig_event_sel <= 4'h0;
         trig_edge_sel <= 2'h0;
         overrun_overwrite <= 1'b0;
         continuous_sel <= 1'b0;
         wait_mode_en <= 1'b0;
         auto_off_en <= 1'b0;
         discontinuous_en <= 1'b0;
         wd_enable <= 1'b0;
         wd_single_channel <= 1'b0;
         wd_channel_sel <= 5'h00;
         segmented_en <= 1'b0;
         conv_gap_cycles <= 15'h0000;
         clock_source_sel <= 1'b0;
         bus_clock_divider <= 3'h0;
         clock_mode_sel <= 2'h0;
         sample_half_cycles <= SMP_HALF_CYC[0];
         seg2_trig_event <= 4'h0;
         seg2_trig_edge <= 2'h0;
         seg3_trig_event <= 4'h0;
         seg3_trig_edge <= 2'h0;
      end else begin
         dma_enable <= cfg1_q[CFG1_DMA_EN];
         // circular only means something while dma is on
         dma_circular <= cfg1_q[CFG1_DMA_EN] & cfg1_q[CFG1_DMA_CIRC];
         scan_backward <= cfg1_q[CFG1_SCAN_BK];
         resolution_sel <= cfg1_q[CFG1_RES_LO +: 2];
         left_align <= cfg1_q[CFG1_ALIGN];
         trig_event_sel <= cfg1_q[CFG1_TEV_LO +: 4];
         trig_edge_sel <= cfg1_q[CFG1_TEDGE_LO +: 2];
         overrun_overwrite <= cfg1_q[CFG1_OVR];
         continuous_sel <= cfg1_q[CFG1_CONT];
         wait_mode_en <= cfg1_q[CFG1_WAIT];
         auto_off_en <= cfg1_q[CFG1_AUTO_OFF];
         discontinuous_en <= cfg1_q[CFG1_DISC];
         wd_enable <= cfg1_q[CFG1_WD_EN];
         wd_single_channel <= cfg1_q[CFG1_WD_SINGLE];
         // reserved codes above 18 pass through; the core ignores them
         wd_channel_sel <= cfg1_q[CFG1_WD_CH_LO +: 5];
         segmented_en <= cfg2_q[CFG2_SEG_EN];
         conv_gap_cycles <= cfg2_q[CFG2_GAP_LO +: 15];
         clock_source_sel <= cfg2_q[CFG2_CSRC];
         bus_clock_divider <= cfg2_q[CFG2_DIV_LO +: 3];
         clock_mode_sel <= cfg2_q[CFG2_CMODE_LO +: 2];
         sample_half_cycles <= SMP_HALF_CYC[smp_q[2:0]];
         seg2_trig_edge <= cfg3_q[CFG3_E2_LO +: 2];
         seg2_trig_event <= cfg3_q[CFG3_T2_LO +: 4];
         seg3_trig_edge <= cfg3_q[CFG3_E3_LO +: 2];
         seg3_trig_event <= cfg3_q[CFG3_T3_LO +: 4];
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_seg_flag_set: assert property (@(posedge core_clk) disable iff (reset)
      core_event[BIT_SEG1_DONE] |=> status_q[BIT_SEG1_DONE])
      else $error("segment flag not set");
   a_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
      (|(status_q & irq_en_q)) |=> irq_out)
      else $error("irq not raised");
   a_cfg_lock: assert property (@(posedge core_clk) disable iff (reset)
      converting |=> $stable(cfg1_q) || !$past(converting))
      else $error("config changed while converting");
   a_enable_gate: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctrl_q[BIT_ENABLE]) |-> $past(ctrl_q) == RESET_ZERO)
      else $error("enable set with control nonzero");
   a_disable_gate: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctrl_q[BIT_DISABLE]) |-> $past(ctrl_q[BIT_ENABLE])
         && !$past(ctrl_q[BIT_START]))
      else $error("disable set illegally");
   a_start_gate: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctrl_q[BIT_START]) |-> $past(ctrl_q[BIT_ENABLE])
         && !$past(ctrl_q[BIT_DISABLE]))
      else $error("start set illegally");
   a_stop_gate: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctrl_q[BIT_STOP]) |-> $past(ctrl_q[BIT_START]))
      else $error("stop set illegally");
   a_cal_clear: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_q[BIT_CAL] && core_cal_done |=> !ctrl_q[BIT_CAL])
      else $error("calibrate not cleared");
   a_cfg2_lock: assert property (@(posedge core_clk) disable iff (reset)
      !idle_all |=> $stable(cfg2_q))
      else $error("config two changed while busy");
   a_bus_answer: assert property (@(posedge core_clk) disable iff (reset)
      (read || write) && waitrequest |=> !waitrequest)
      else $error("bus not answered");
endmodule

// ==== tb/conv_core_model.sv ====
// behavioural analog core facing the converter control block
// assumes requests are levels on core_clk; answers come as 1-cycle pulses
`timescale 1ns/1ps
module conv_core_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // requests from the control block
   input  wire logic        conv_disable,
   input  wire logic        stop_conv,
   input  wire logic        cal_busy,
   // bench commands
   input  wire logic [10:0] ev_cmd,
   input  wire logic        done_cmd,
   input  wire logic [3:0]  dly,
   // answers to the control block
   output logic [10:0]      core_event,
   output logic             core_ready_ack,
   output logic             core_off_ack,
   output logic             core_conv_done,
   output logic             core_stop_ack,
   output logic             core_cal_done
);
   logic [2:0] req;
   logic [2:0] req_q;
   logic [2:0] ack_q;
   logic [3:0] cnt_q [3];

   assign req            = {cal_busy, stop_conv, conv_disable};
   assign core_off_ack   = ack_q[0];
   assign core_stop_ack  = ack_q[1];
   assign core_cal_done  = ack_q[2];
   assign core_ready_ack = 1'b0;

   // dly sets how slowly each request is answered; it must be at least 1
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         req_q          <= 3'h0;
         ack_q          <= 3'h0;
         core_event     <= 11'h0;
         core_conv_done <= 1'b0;
         for (int i = 0; i < 3; i++)
            cnt_q[i] <= 4'h0;
      end else begin
         req_q          <= req;
         core_event     <= ev_cmd;
         core_conv_done <= done_cmd;
         for (int i = 0; i < 3; i++) begin
            ack_q[i] <= 1'b0;
            if (req[i] && !req_q[i])
               cnt_q[i] <= dly;
            else if (cnt_q[i] == 4'h1) begin
               cnt_q[i] <= 4'h0;
               ack_q[i] <= 1'b1;
            end else if (cnt_q[i] != 4'h0)
               cnt_q[i] <= cnt_q[i] - 4'h1;
         end
      end
   end
endmodule

// ==== tb/tb_conv_ctrl.sv ====
// self-checking bench of the converter control block
// assumes the avalon slave drops waitrequest to answer; the watchdog ends hangs
`timescale 1ns/1ps
module tb_conv_ctrl
   import conv_ctrl_pkg::*;
;
   logic        core_clk, reset, read, write, waitrequest, done_cmd;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0]  byteenable, dly;
   logic [10:0] ev_cmd, core_event;
   logic        core_ready_ack, core_off_ack, core_conv_done, core_stop_ack;
   logic        core_cal_done, conv_enable, conv_disable, start_conv;
   logic        stop_conv, cal_busy, irq_out, dma_enable, dma_circular;
   logic        scan_backward, left_align, overrun_overwrite, core_powered;
   logic        continuous_sel, wait_mode_en, auto_off_en, discontinuous_en;
   logic        wd_enable, wd_single_channel, segmented_en, clock_source_sel;
   logic [1:0]  resolution_sel, trig_edge_sel, clock_mode_sel;
   logic [1:0]  seg2_trig_edge, seg3_trig_edge;
   logic [3:0]  trig_event_sel, seg2_trig_event, seg3_trig_event;
   logic [4:0]  wd_channel_sel;
   logic [14:0] conv_gap_cycles;
   logic [2:0]  bus_clock_divider;
   logic [8:0]  sample_half_cycles;
   logic [23:0] cfg1_out;
   logic [21:0] cfg2_out;
   logic [11:0] cfg3_out;
   int          errors, checks_done;
   // sampling time in half converter clocks, 3 up to 479 (1.5 to 239.5 clocks)
   logic [31:0] smp_half [8] = '{32'h3, 32'hF, 32'h1B, 32'h39, 32'h53,
      32'h6F, 32'h8F, 32'h1DF};
   logic [31:0] flags [9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h80,
      32'h100, 32'h200, 32'h400};
   logic [31:0] locks [3] = '{32'h2, 32'h4, 32'h10};

   assign cfg1_out = {dma_enable, dma_circular, scan_backward, resolution_sel,
      left_align, trig_event_sel, trig_edge_sel, overrun_overwrite,
      continuous_sel, wait_mode_en, auto_off_en, discontinuous_en, wd_enable,
      wd_single_channel, wd_channel_sel};
   assign cfg2_out = {segmented_en, conv_gap_cycles, clock_source_sel,
      bus_clock_divider, clock_mode_sel};
   assign cfg3_out = {seg2_trig_event, seg2_trig_edge, seg3_trig_event,
      seg3_trig_edge};

   conv_ctrl dut (.core_clk, .reset, .address, .read, .write, .writedata,
      .byteenable, .readdata, .waitrequest, .core_event, .core_ready_ack,
      .core_off_ack, .core_conv_done, .core_stop_ack, .core_cal_done,
      .conv_enable, .conv_disable, .start_conv, .stop_conv, .cal_busy,
      .irq_out, .dma_enable, .dma_circular, .scan_backward, .resolution_sel,
      .left_align, .trig_event_sel, .trig_edge_sel, .overrun_overwrite,
      .continuous_sel, .wait_mode_en, .auto_off_en, .discontinuous_en,
      .wd_enable, .wd_single_channel, .wd_channel_sel, .segmented_en,
      .conv_gap_cycles, .clock_source_sel, .bus_clock_divider,
      .clock_mode_sel, .sample_half_cycles, .seg2_trig_event,
      .seg2_trig_edge, .seg3_trig_event, .seg3_trig_edge, .core_powered);
   conv_core_model core (.core_clk, .reset, .conv_disable, .stop_conv,
      .cal_busy, .ev_cmd, .done_cmd, .dly, .core_event, .core_ready_ack,
      .core_off_ack, .core_conv_done, .core_stop_ack, .core_cal_done);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------------
   // bus cycles and comparisons
   // ------------------------------------------------------------------
   // one access; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      @(posedge core_clk);
      while (waitrequest !== 1'b0)
         @(posedge core_clk);
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic test_done;
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      for (int a = 0; a <= 8'h1C; a += 4)
         rchk(8'(a), 32'h0);
      chk(32'(sample_half_cycles), 32'h3);
   endtask

   task automatic t_control;
      foreach (locks[i]) begin
         bus(1'b1, OFS_CONTROL, locks[i]);
         rchk(OFS_CONTROL, 32'h0);
      end
      bus(1'b1, OFS_CONTROL, 32'h1);
      rchk(OFS_CONTROL, 32'h1);
      bus(1'b1, OFS_CONTROL, 32'h8000_0000);
      rchk(OFS_CONTROL, 32'h1);
      bus(1'b1, OFS_CONTROL, 32'h4);
      rchk(OFS_CONTROL, 32'h5);
      chk(32'({conv_enable, start_conv}), 32'h3);
      // control itself is skipped: all ones would legally set stop
      for (int a = 4; a <= 8'h18; a += 4) begin
         if (a != 8) begin
            bus(1'b1, 8'(a), 32'hFFFF_FFFF);
            rchk(8'(a), 32'h0);
         end
      end
      bus(1'b1, OFS_CONTROL, 32'h2);
      rchk(OFS_CONTROL, 32'h5);
      bus(1'b1, OFS_CONTROL, 32'h10);
      rchk(OFS_CONTROL, 32'h15);
      chk(32'({stop_conv, start_conv}), 32'h3);
      tick(16);
      rchk(OFS_CONTROL, 32'h1);
      bus(1'b1, OFS_CONTROL, 32'h4);
      done_cmd <= 1'b1;
      tick(1);
      done_cmd <= 1'b0;
      tick(3);
      rchk(OFS_CONTROL, 32'h1);
      dly <= 4'h1;
      bus(1'b1, OFS_CONTROL, 32'h2);
      tick(1);
      chk(32'(conv_disable), 32'h1);
      tick(5);
      rchk(OFS_CONTROL, 32'h0);
      chk(32'({conv_enable, core_powered, conv_disable}), 32'h0);
      dly <= 4'h8;
      bus(1'b1, OFS_CONTROL, 32'h8000_0000);
      rchk(OFS_CONTROL, 32'h8000_0000);
      chk(32'(cal_busy), 32'h1);
      tick(16);
      rchk(OFS_CONTROL, 32'h0);
   endtask

   task automatic t_cfg;
      bus(1'b1, OFS_CONFIG_ONE, 32'h4BFF_FFBF);
      rchk(OFS_CONFIG_ONE, 32'h48C1_FFBF);
      chk(32'(cfg1_out), 32'hFFBFF2);
      bus(1'b1, OFS_CONFIG_ONE, 32'h2);
      tick(2);
      chk(32'({dma_enable, dma_circular}), 32'h0);
      bus(1'b1, OFS_CONFIG_TWO, 32'h7FFF_FFFF);
      rchk(OFS_CONFIG_TWO, 32'h7C7F_FF01);
      chk(32'(cfg2_out), 32'h3FFFFD);
      bus(1'b1, OFS_CONFIG_THREE, 32'hFFFF_3D3B);
      rchk(OFS_CONFIG_THREE, 32'h3D3B);
      chk(32'(cfg3_out), 32'hEFD);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, OFS_SAMPLE_TIME, 32'hFFFF_FFF8 | 32'(i));
         rchk(OFS_SAMPLE_TIME, 32'(i));
         chk(32'(sample_half_cycles), smp_half[i]);
      end
   endtask

   task automatic t_status;
      ev_cmd <= 11'h7FF;
      tick(1);
      ev_cmd <= 11'h0;
      tick(3);
      rchk(OFS_STATUS, 32'h79F);
      chk(32'(irq_out), 32'h0);
      foreach (flags[i]) begin
         bus(1'b1, OFS_IRQ_ENABLE, flags[i]);
         tick(2);
         chk(32'(irq_out), 32'h1);
         bus(1'b1, OFS_STATUS, flags[i]);
         tick(2);
         chk(32'(irq_out), 32'h0);
      end
      rchk(OFS_STATUS, 32'h0);
      bus(1'b1, OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
      rchk(OFS_IRQ_ENABLE, 32'h79F);
   endtask

   initial begin
      reset       = 1'b1;
      read        = 1'b0;
      write       = 1'b0;
      address     = 8'h00;
      writedata   = 32'h0;
      byteenable  = 4'hF;
      ev_cmd      = 11'h0;
      done_cmd    = 1'b0;
      dly         = 4'h8;
      errors      = 0;
      checks_done = 0;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      t_reset;
      t_control;
      t_cfg;
      t_status;
      test_done;
   end

   // the scenarios need well under a thousand cycles
   initial begin
      #400000;
      errors++;
      test_done;
   end
endmodule
